// File: logic/slm_pkg.sv
// Constants shared by the serial lane error monitor.
// What this block does
// (R1) Detect disparity, not-in-table and unexpected control character errors per lane.
// (R2) Disparity errors count even on characters missing from the code table.
// (R3) One independent counter per lane and per error type.
// (R4) Count select holds lane in [6:4] and type in [1:0].
// (R5) Reading count select returns the count last selected by a write.
// (R6) Page bit picks the link; second link lane x means lane x plus four.
// (R7) Counters stop when equal to the threshold; threshold is maximum count.
// (R8) One threshold serves all lanes and all three error types.
// (R9) Three readable status registers report per-type threshold reached.
// (R10) Writes to status registers are commands; reads return status only.
// (R11) Bit 7 clears that type's interrupt for the lane in bits [2:0].
// (R12) Bit 6 disables that type's counting for the lane in bits [2:0].
// (R13) Bit 5 clears that type's counter for the lane in bits [2:0].
// (R14) Any error pulses the active-low sync request output.
// (R15) Error pulse width selectable as half, one or two parallel clocks.
// (R16) Software picks duration 0 or 1 to get two frames per mode.
// (R17) Optionally raise sync request and reinitialize on threshold reached.
// (R18) Four bad disparity characters always reinitialize; request is 5 frames plus 9 octets.
// (R19) Threshold events per type can be enabled and read back as interrupts.
// (R20) A disabled counter never increments but still clears on a clear command or link reinit.
package slm_pkg;

  localparam int unsigned LANES      = 8;
  localparam int unsigned TYPES      = 3;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned REG_W      = 8;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
  localparam logic [11:0] IDX_PULSE_DUR = 12'h312;
  localparam logic [11:0] IDX_COUNT_SEL = 12'h46B;
  localparam logic [11:0] IDX_DISP_STAT = 12'h46D;
  localparam logic [11:0] IDX_NIT_STAT  = 12'h46E;
  localparam logic [11:0] IDX_UCC_STAT  = 12'h46F;
  localparam logic [11:0] IDX_IRQ_EN    = 12'h47A;
  localparam logic [11:0] IDX_SYNC_MASK = 12'h47B;
  localparam logic [11:0] IDX_THRESH    = 12'h47C;

  // Field positions
  localparam int unsigned PAGE_LINK_BIT   = 2;
  localparam int unsigned DUR_LSB         = 4;
  localparam int unsigned SEL_LANE_LSB    = 4;
  localparam int unsigned SEL_TYPE_LSB    = 0;
  localparam int unsigned CTL_CLR_IRQ_BIT = 7;
  localparam int unsigned CTL_OFF_BIT     = 6;
  localparam int unsigned CTL_CLR_CNT_BIT = 5;
  localparam int unsigned CTL_LANE_LSB    = 0;
  localparam int unsigned TYPE_TOP_BIT    = 7;

  // Error types and pulse durations
  localparam logic [1:0] TYPE_DISP = 2'h0;
  localparam logic [1:0] TYPE_NIT  = 2'h1;
  localparam logic [1:0] TYPE_UCC  = 2'h2;
  localparam logic [1:0] DUR_HALF  = 2'h0;
  localparam logic [1:0] DUR_ONE   = 2'h1;

  // Reset values
  localparam logic [7:0] PAGE_RST   = 8'h00;
  localparam logic [1:0] DUR_RST    = 2'h0;
  localparam logic [7:0] THRESH_RST = 8'hFF;
  localparam logic [2:0] MASK3_RST  = 3'h0;

  // Lane mapping and reinitialization timing
  localparam logic [3:0] LINK1_LANE_OFFSET = 4'h4;
  localparam logic [2:0] DISP_REINIT_COUNT = 3'h4;
  localparam int unsigned RESYNC_FRAMES    = 5;
  localparam int unsigned RESYNC_OCTETS    = 9;

endpackage

// File: logic/slm_err_counter.sv
// One saturating error counter with its disable and interrupt flag.
`timescale 1ns/1ps
module slm_err_counter #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             err_in,
  input  wire logic             wr_hit,
  input  wire logic             wr_clr_irq,
  input  wire logic             wr_off,
  input  wire logic             wr_clr_cnt,
  input  wire logic             link_reinit,
  input  wire logic [CNT_W-1:0] threshold,
  output logic      [CNT_W-1:0] count,
  output logic                  at_threshold,
  output logic                  reach_pulse,
  output logic                  irq_flag
);

  logic [CNT_W-1:0] count_q;
  logic             off_q;
  logic             irq_q;
  logic             inc;
  logic [CNT_W:0]   count_plus;

  // (R7) Saturate at threshold; (R20) no increment while off
  assign inc         = err_in & ~off_q & (count_q < threshold);
  assign count_plus  = {1'b0, count_q} + {{CNT_W{1'b0}}, 1'b1};
  assign reach_pulse = inc & (count_plus == {1'b0, threshold});

  // (R13) Counter clear; clear beats a same-cycle error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (link_reinit || (wr_hit && wr_clr_cnt)) begin
      count_q <= '0;
    end else if (inc) begin
      count_q <= count_plus[CNT_W-1:0];
    end
  end

  // (R12) Disable follows the last control write to this lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_q <= 1'b0;
    end else if (wr_hit) begin
      off_q <= wr_off;
    end
  end

  // (R11) Interrupt clear; a new reach event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (reach_pulse) begin
      irq_q <= 1'b1;
    end else if (wr_hit && wr_clr_irq) begin
      irq_q <= 1'b0;
    end
  end

  assign count        = count_q;
  assign at_threshold = (count_q >= threshold);
  assign irq_flag     = irq_q;

endmodule // slm_err_counter

// File: logic/slm_lane_error_monitor.sv
// Lane error monitor top: APB registers, error detection, counters and sync pulse.
`timescale 1ns/1ps
module slm_lane_error_monitor #(
  parameter int unsigned CNT_W            = 8,
  parameter int unsigned OCTETS_PER_FRAME = 2,
  parameter int unsigned FRAMES_PER_PCLK  = 4
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [slm_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [slm_pkg::LANES-1:0]    char_valid,
  input  wire logic [slm_pkg::LANES-1:0]    disparity_bad,
  input  wire logic [slm_pkg::LANES-1:0]    not_in_table,
  input  wire logic [slm_pkg::LANES-1:0]    is_control,
  input  wire logic [slm_pkg::LANES-1:0]    control_allowed,
  output logic      [1:0]                   sync_request_out_n,
  output logic                              link_reinit
);

  localparam int unsigned LANES = slm_pkg::LANES;
  localparam int unsigned TYPES = slm_pkg::TYPES;

  // Sync request length after a reinit, rounded up to whole parallel clocks
  localparam int unsigned RESYNC_OCT_TOTAL = slm_pkg::RESYNC_FRAMES * OCTETS_PER_FRAME + slm_pkg::RESYNC_OCTETS;
  localparam int unsigned OCT_PER_PCLK     = OCTETS_PER_FRAME * FRAMES_PER_PCLK;
  localparam int unsigned RESYNC_CYCLES    = (RESYNC_OCT_TOTAL + OCT_PER_PCLK - 1) / OCT_PER_PCLK;
  localparam logic [7:0]  RESYNC_LOAD      = 8'(RESYNC_CYCLES);

  localparam logic [slm_pkg::ADDR_W-1:0] A_PAGE   = {slm_pkg::IDX_LINK_PAGE, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_DUR    = {slm_pkg::IDX_PULSE_DUR, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_SEL    = {slm_pkg::IDX_COUNT_SEL, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_DSTAT  = {slm_pkg::IDX_DISP_STAT, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_NSTAT  = {slm_pkg::IDX_NIT_STAT, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_USTAT  = {slm_pkg::IDX_UCC_STAT, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_IRQEN  = {slm_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_SMASK  = {slm_pkg::IDX_SYNC_MASK, 2'b00};
  localparam logic [slm_pkg::ADDR_W-1:0] A_THRESH = {slm_pkg::IDX_THRESH, 2'b00};

  // Link lane to logical lane; bit 3 set means out of range
  function automatic logic [3:0] map_lane(input logic [2:0] link_lane, input logic link1);
    map_lane = {1'b0, link_lane} + (link1 ? slm_pkg::LINK1_LANE_OFFSET : 4'h0);
  endfunction

  // Known register address
  function automatic logic addr_known(input logic [slm_pkg::ADDR_W-1:0] a);
    addr_known = (a == A_PAGE) || (a == A_DUR) || (a == A_SEL) || (a == A_DSTAT) || (a == A_NSTAT)
                 || (a == A_USTAT) || (a == A_IRQEN) || (a == A_SMASK) || (a == A_THRESH);
  endfunction

  logic [7:0]             page_q;
  logic [1:0]             dur_q;
  logic [3:0]             sel_lane_q;
  logic [1:0]             sel_type_q;
  logic [2:0]             irq_en_q;
  logic [2:0]             sync_mask_q;
  logic [CNT_W-1:0]       thresh_q;
  logic [31:0]            prdata_q;
  logic                   pslverr_q;
  logic                   setup;
  logic                   wr_access;
  logic                   wr_byte0;
  logic [7:0]             wbyte;
  logic [3:0]             ctl_lane;
  logic [TYPES-1:0]       ctl_hit_type;
  logic [TYPES-1:0][LANES-1:0] err_det;
  logic [TYPES-1:0][LANES-1:0] at_thr;
  logic [TYPES-1:0][LANES-1:0] reach;
  logic [TYPES-1:0][LANES-1:0] irq_flag;
  logic [TYPES-1:0][LANES-1:0][CNT_W-1:0] cnt;
  logic [LANES-1:0][2:0]  disp_run_q;
  logic                   disp_four;
  logic                   thresh_reinit;
  logic                   reinit_q;
  logic [7:0]             resync_q;
  logic [1:0]             pulse_q;
  logic                   half_q;
  logic                   any_err;
  logic [1:0]             sync_n_q;
  logic [7:0]             rd_val;

  // APB phases: read data is captured in setup, writes act in the access phase
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign wr_byte0  = wr_access & pstrb[0] & addr_known(paddr);
  assign wbyte     = pwdata[7:0];

  // (R1) Character error detection per lane
  // (R2) Disparity not gated by table lookup
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      err_det[0][l] = char_valid[l] & disparity_bad[l];
      err_det[1][l] = char_valid[l] & not_in_table[l];
      err_det[2][l] = char_valid[l] & is_control[l] & ~control_allowed[l] & ~not_in_table[l];
    end
  end

  // (R6) Control write lane resolved through the page bit
  assign ctl_lane = map_lane(wbyte[slm_pkg::CTL_LANE_LSB +: 3], page_q[slm_pkg::PAGE_LINK_BIT]);

  // (R10) Status addresses decode as commands per type
  assign ctl_hit_type[0] = wr_byte0 && (paddr == A_DSTAT);
  assign ctl_hit_type[1] = wr_byte0 && (paddr == A_NSTAT);
  assign ctl_hit_type[2] = wr_byte0 && (paddr == A_USTAT);

  // (R3) One counter per lane and type
  for (genvar t = 0; t < TYPES; t++) begin : g_type
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      slm_err_counter #(
        .CNT_W (CNT_W)
      ) u_cnt (
        .pclk         (pclk),
        .presetn      (presetn),
        .err_in       (err_det[t][l]),
        // (R11) (R12) (R13) Command targets one lane of one type
        .wr_hit       (ctl_hit_type[t] && (ctl_lane == 4'(l))),
        .wr_clr_irq   (wbyte[slm_pkg::CTL_CLR_IRQ_BIT]),
        .wr_off       (wbyte[slm_pkg::CTL_OFF_BIT]),
        .wr_clr_cnt   (wbyte[slm_pkg::CTL_CLR_CNT_BIT]),
        .link_reinit  (reinit_q),
        // (R8) Shared threshold
        .threshold    (thresh_q),
        .count        (cnt[t][l]),
        .at_threshold (at_thr[t][l]),
        .reach_pulse  (reach[t][l]),
        .irq_flag     (irq_flag[t][l])
      );
    end
  end

  // Configuration registers written from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q      <= slm_pkg::PAGE_RST;
      dur_q       <= slm_pkg::DUR_RST;
      irq_en_q    <= slm_pkg::MASK3_RST;
      sync_mask_q <= slm_pkg::MASK3_RST;
      thresh_q    <= CNT_W'(slm_pkg::THRESH_RST);
    end else if (wr_byte0) begin
      if (paddr == A_PAGE) begin
        page_q <= wbyte;
      end
      // (R15) Pulse width field
      if (paddr == A_DUR) begin
        dur_q <= wbyte[slm_pkg::DUR_LSB +: 2];
      end
      // (R19) Per-type interrupt enables
      if (paddr == A_IRQEN) begin
        irq_en_q <= wbyte[slm_pkg::TYPE_TOP_BIT -: 3];
      end
      // (R17) Per-type reinit on threshold
      if (paddr == A_SMASK) begin
        sync_mask_q <= wbyte[slm_pkg::TYPE_TOP_BIT -: 3];
      end
      if (paddr == A_THRESH) begin
        thresh_q <= wbyte[CNT_W-1:0];
      end
    end
  end

  // (R4) (R5) Selection latched with the page in force at the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lane_q <= 4'h0;
      sel_type_q <= slm_pkg::TYPE_DISP;
    end else if (wr_byte0 && (paddr == A_SEL)) begin
      sel_lane_q <= map_lane(wbyte[slm_pkg::SEL_LANE_LSB +: 3], page_q[slm_pkg::PAGE_LINK_BIT]);
      sel_type_q <= wbyte[slm_pkg::SEL_TYPE_LSB +: 2];
    end
  end

  // Read value of an address; status bits follow link lanes of the current page
  always_comb begin
    logic [3:0] lg;
    lg     = 4'h0;
    rd_val = 8'h00;
    unique case (paddr)
      A_PAGE:  rd_val = page_q;
      A_DUR:   rd_val = {2'b00, dur_q, 4'h0};
      // (R5) Count readback of selected counter
      A_SEL: begin
        if (!sel_lane_q[3] && (sel_type_q != 2'h3)) begin
          rd_val = 8'(cnt[sel_type_q][sel_lane_q[2:0]]);
        end
      end
      // (R9) Per-type threshold status
      A_DSTAT, A_NSTAT, A_USTAT: begin
        for (int x = 0; x < LANES; x++) begin
          lg = map_lane(3'(x), page_q[slm_pkg::PAGE_LINK_BIT]);
          if (!lg[3]) begin
            rd_val[x] = (paddr == A_DSTAT) ? at_thr[0][lg[2:0]] :
                        (paddr == A_NSTAT) ? at_thr[1][lg[2:0]] : at_thr[2][lg[2:0]];
          end
        end
      end
      // (R19) Enabled interrupt status in the same bits
      A_IRQEN: begin
        for (int t = 0; t < TYPES; t++) begin
          rd_val[slm_pkg::TYPE_TOP_BIT - t] = irq_en_q[2 - t] & (|irq_flag[t]);
        end
      end
      A_SMASK:  rd_val = {sync_mask_q, 5'h00};
      A_THRESH: rd_val = 8'(thresh_q);
      default:  rd_val = 8'h00;
    endcase
  end

  // Read data and error captured in setup so they stand through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= {24'h00_0000, rd_val};
      pslverr_q <= ~addr_known(paddr);
    end
  end

  // Every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // (R18) Count of bad disparity characters per lane since the last reinit, good characters between do not reset it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_run_q <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (reinit_q) begin
          disp_run_q[l] <= 3'h0;
        end else if (err_det[0][l] && (disp_run_q[l] != slm_pkg::DISP_REINIT_COUNT)) begin
          disp_run_q[l] <= disp_run_q[l] + 3'h1;
        end
      end
    end
  end

  always_comb begin
    disp_four = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      disp_four = disp_four | (disp_run_q[l] == slm_pkg::DISP_REINIT_COUNT);
    end
  end

  // (R17) Masked threshold events trigger a reinit
  always_comb begin
    thresh_reinit = 1'b0;
    for (int t = 0; t < TYPES; t++) begin
      thresh_reinit = thresh_reinit | (sync_mask_q[2 - t] & (|reach[t]));
    end
  end

  // Reinit pulse and sync request hold; a trigger during a hold restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reinit_q <= 1'b0;
      resync_q <= 8'h00;
    end else begin
      reinit_q <= (disp_four | thresh_reinit) & ~reinit_q;
      if ((disp_four | thresh_reinit) && !reinit_q) begin
        resync_q <= RESYNC_LOAD;
      end else if (resync_q != 8'h00) begin
        resync_q <= resync_q - 8'h01;
      end
    end
  end

  assign link_reinit = reinit_q;

  // (R14) Any error of any type on any lane
  assign any_err = |{err_det[0], err_det[1], err_det[2]};

  // (R15) Pulse of half, one or two parallel clocks; (R16) duration chosen by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 2'h0;
      half_q  <= 1'b0;
    end else if (any_err) begin
      half_q  <= (dur_q == slm_pkg::DUR_HALF);
      pulse_q <= (dur_q == slm_pkg::DUR_HALF) ? 2'h0 : (dur_q == slm_pkg::DUR_ONE) ? 2'h1 : 2'h2;
    end else begin
      half_q  <= 1'b0;
      pulse_q <= (pulse_q != 2'h0) ? pulse_q - 2'h1 : 2'h0;
    end
  end

  // Output slots: bit 0 first half cycle, bit 1 second half; low means request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_n_q <= 2'b11;
    end else begin
      sync_n_q[0] <= ~(half_q | (pulse_q != 2'h0) | (resync_q != 8'h00));
      sync_n_q[1] <= ~((pulse_q != 2'h0) | (resync_q != 8'h00));
    end
  end

  assign sync_request_out_n = sync_n_q;

endmodule // slm_lane_error_monitor

// File: sim/slm_lane_error_monitor_properties.sv
// Port level checks for the lane error monitor.
`timescale 1ns/1ps
module slm_lane_error_monitor_properties #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [slm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic [slm_pkg::LANES-1:0]  char_valid,
  input wire logic [slm_pkg::LANES-1:0]  disparity_bad,
  input wire logic [slm_pkg::LANES-1:0]  not_in_table,
  input wire logic [slm_pkg::LANES-1:0]  is_control,
  input wire logic [slm_pkg::LANES-1:0]  control_allowed,
  input wire logic [1:0]                 sync_request_out_n,
  input wire logic                       link_reinit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0]                thr_q;
  logic [slm_pkg::LANES-1:0] err_w;
  logic                      rd_acc;

  // Any character fault on any lane
  assign err_w  = char_valid & (disparity_bad | not_in_table | (is_control & ~control_allowed));
  assign rd_acc = psel && penable && !pwrite;

  // Threshold shadow, kept apart from the design's state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= slm_pkg::THRESH_RST;
    end else if (psel && penable && pwrite && pstrb[0] && paddr == {slm_pkg::IDX_THRESH, 2'b00}) begin
      thr_q <= pwdata[7:0];
    end
  end

  // Sync pulse, reinit and register readback
  a_err_pulse: assert property (|err_w |-> ##[1:3] sync_request_out_n != 2'b11)
    else $error("no sync pulse");
  a_half_slot: assert property (sync_request_out_n != 2'b01)
    else $error("half pulse slot");
  a_reinit_once: assert property (link_reinit |=> !link_reinit)
    else $error("reinit too long");
  a_reinit_hold: assert property (link_reinit |-> ##1 (sync_request_out_n == 2'b00) [*3])
    else $error("resync too short");
  a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h000000)
    else $error("prdata upper bits");
  a_thresh_read: assert property (rd_acc && paddr == {slm_pkg::IDX_THRESH, 2'b00} |-> prdata[7:0] == thr_q)
    else $error("threshold readback");
  a_count_cap: assert property (rd_acc && paddr == {slm_pkg::IDX_COUNT_SEL, 2'b00} |-> prdata[7:0] <= thr_q)
    else $error("count above threshold");
  a_ready_one: assert property (psel && penable |-> pready)
    else $error("pready low");

  cover property (link_reinit);
  cover property (rd_acc && paddr == {slm_pkg::IDX_COUNT_SEL, 2'b00} && prdata[7:0] == thr_q);
  cover property (sync_request_out_n == 2'b00 && !link_reinit);
endmodule // slm_lane_error_monitor_properties

// File: sim/slm_tx_model.sv
// Transmitter model: clean characters, errors injected on request.
`timescale 1ns/1ps
module slm_tx_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       inj_go,
  input  wire logic [1:0] inj_kind,
  input  wire logic [2:0] inj_lane,
  output logic      [7:0] char_valid,
  output logic      [7:0] disparity_bad,
  output logic      [7:0] not_in_table,
  output logic      [7:0] is_control,
  output logic      [7:0] control_allowed
);
  logic [7:0] pat_q;
  logic [7:0] hit;

  // Kinds: 0 disparity, 1 untabled, 2 stray control, 3 disparity on untabled code
  assign hit = inj_go ? (8'h01 << inj_lane) : 8'h00;

  // three error kinds, disparity on untabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_q           <= 8'h5A;
      char_valid      <= 8'h00;
      disparity_bad   <= 8'h00;
      not_in_table    <= 8'h00;
      is_control      <= 8'h00;
      control_allowed <= 8'h00;
    end else begin
      pat_q           <= {pat_q[6:0], pat_q[7] ^ pat_q[5]};
      char_valid      <= 8'hFF;
      disparity_bad   <= (inj_kind == 2'h0 || inj_kind == 2'h3) ? hit : 8'h00;
      not_in_table    <= inj_kind[0] ? hit : 8'h00;
      // Expected control chars follow the pattern; only injected ones are stray
      is_control      <= pat_q | ((inj_kind == 2'h2) ? hit : 8'h00);
      control_allowed <= pat_q & ~((inj_kind == 2'h2) ? hit : 8'h00);
    end
  end
endmodule // slm_tx_model

// File: sim/serial_lane_error_monitor_tb_top.sv
// Self-checking bench for the lane error monitor.
`timescale 1ns/1ps
module serial_lane_error_monitor_tb_top;
  localparam logic [7:0] THR = 8'h03;
  localparam logic [11:0] SEL = slm_pkg::IDX_COUNT_SEL, NIT = slm_pkg::IDX_NIT_STAT, DSP = slm_pkg::IDX_DISP_STAT;
  localparam logic [11:0] THA = slm_pkg::IDX_THRESH, IRQ = slm_pkg::IDX_IRQ_EN, PAG = slm_pkg::IDX_LINK_PAGE;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, link_reinit, inj_go, last_err;
  logic [slm_pkg::ADDR_W-1:0] paddr;
  logic [31:0]               pwdata, prdata;
  logic [7:0]                char_valid, disparity_bad, not_in_table, is_control, control_allowed, dmy;
  logic [1:0]                sync_request_out_n, inj_kind, k, dd, first;
  logic [2:0]                inj_lane, l;
  int                        fail_count, cmp_count, reinit_seen, n, lowc;

  slm_lane_error_monitor slm_lane_error_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .char_valid(char_valid), .disparity_bad(disparity_bad),
    .not_in_table(not_in_table), .is_control(is_control), .control_allowed(control_allowed),
    .sync_request_out_n(sync_request_out_n), .link_reinit(link_reinit));
  slm_tx_model slm_tx_model_i (.pclk(pclk), .presetn(presetn), .inj_go(inj_go), .inj_kind(inj_kind),
    .inj_lane(inj_lane), .char_valid(char_valid), .disparity_bad(disparity_bad), .not_in_table(not_in_table),
    .is_control(is_control), .control_allowed(control_allowed));

  // Clock at 250 MHz
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Count reinit pulses
  always @(posedge pclk) if (link_reinit === 1'b1) reinit_seen++;

  function automatic logic [7:0] exp_cnt(input int cnt, input logic [7:0] thr);
    return (cnt < thr) ? 8'(cnt) : thr;
  endfunction
  function automatic logic [7:0] exp_low(input logic [1:0] dur);
    return (dur >= 2'h2) ? 8'h02 : 8'h01;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; only the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {a, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r        = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, dmy);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(nm, e, r);
  endtask
  // cnt errors on one lane, then settle time
  task automatic inj(input logic [1:0] kd, input logic [2:0] ln, input int cnt);
    @(posedge pclk);
    inj_kind <= kd;
    inj_lane <= ln;
    if (cnt > 0) begin
      inj_go <= 1'b1;
      repeat (cnt) @(posedge pclk);
      inj_go <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask

  // Watchdog, about ninety times the expected run
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, inj_go, last_err} = 6'h00;
    {paddr, pwdata, inj_kind, inj_lane} = '0;
    {fail_count, cmp_count, reinit_seen} = '0;
    void'($urandom(12115));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc("thr reset", THA, 8'hFF);
    rdc("page reset", PAG, 8'h00);
    rdc("unmapped read", 12'h001, 8'h00);
    chk("unmapped err", 8'h01, {7'h00, last_err});
    wr(THA, THR);
    rdc("threshold", THA, THR);
    // Untabled errors on lane 2, then commands
    inj(2'h1, 3'h2, 5);
    wr(SEL, 8'h21);
    rdc("nit count", SEL, exp_cnt(5, THR));
    rdc("nit status", NIT, 8'h04);
    rdc("disp status", DSP, 8'h00);
    wr(IRQ, 8'hE0);
    rdc("irq status", IRQ, 8'h40);
    wr(NIT, 8'hE2);
    rdc("cmd status", NIT, 8'h00);
    rdc("irq cleared", IRQ, 8'h00);
    rdc("count cleared", SEL, 8'h00);
    inj(2'h1, 3'h2, 2);
    rdc("off count", SEL, 8'h00);
    wr(NIT, 8'h02);
    inj(2'h1, 3'h2, 1);
    rdc("on count", SEL, 8'h01);
    // Pulse width per duration code
    for (int d = 0; d < 4; d++) begin
      dd = 2'(d);
      wr(slm_pkg::IDX_PULSE_DUR, {2'b00, dd, 4'h0});
      lowc  = 0;
      first = 2'b11;
      fork
        inj(2'h2, 3'(d + 4), 1);
        repeat (8) begin
          @(negedge pclk);
          if (sync_request_out_n !== 2'b11) begin
            lowc++;
            if (first === 2'b11) first = sync_request_out_n;
          end
        end
      join
      chk("sync low", exp_low(dd), 8'(lowc));
      chk("sync level", (dd == 2'h0) ? 8'h02 : 8'h00, {6'h00, first});
    end
    // Random lane, kind and count
    for (int i = 0; i < 6; i++) begin
      k = 2'(1 + $urandom % 2);
      l = 3'($urandom % 8);
      n = $urandom % 6;
      wr(DSP + {10'h000, k}, {5'b00100, l});
      wr(SEL, {1'b0, l, 2'b00, k});
      inj(k, l, n);
      rdc("random count", SEL, exp_cnt(n, THR));
    end
    // Link 1 lane 1 is logical lane 5
    wr(PAG, 8'h04);
    wr(SEL, 8'h10);
    inj(2'h3, 3'h5, 2);
    rdc("link1 count", SEL, 8'h02);
    wr(PAG, 8'h00);
    // Four disparity errors force a reinit
    wr(SEL, 8'h00);
    inj(2'h0, 3'h0, 3);
    rdc("disp count", SEL, THR);
    rdc("disp status", DSP, 8'h01);
    chk("early reinit", 8'h00, 8'(reinit_seen));
    inj(2'h0, 3'h0, 1);
    rdc("reinit count", SEL, 8'h00);
    chk("reinit pulses", 8'h01, 8'(reinit_seen));
    // Masked threshold reach reinitializes
    wr(slm_pkg::IDX_SYNC_MASK, 8'h20);
    inj(2'h2, 3'h6, 3);
    repeat (4) @(posedge pclk);
    chk("masked reinit", 8'h02, 8'(reinit_seen));
    tally_and_finish();
  end
endmodule // serial_lane_error_monitor_tb_top

bind slm_lane_error_monitor slm_lane_error_monitor_properties #(.CNT_W(CNT_W)) slm_lane_error_monitor_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .char_valid(char_valid),
  .disparity_bad(disparity_bad), .not_in_table(not_in_table), .is_control(is_control),
  .control_allowed(control_allowed), .sync_request_out_n(sync_request_out_n), .link_reinit(link_reinit));
